// *** include/delog_pkg.sv ***
// Purpose: Shared constants and types for the DRAM ECC error logger
// Assumes: AHB-Lite register bus, 32-bit data, one aligned word per register
// Notes: Offsets 0x5d to 0x5f are not word aligned, so offsets are indices
package delog_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_ERR_ADDR = 8'h58;
    localparam logic [7:0] IDX_ERR_SYN = 8'h5c;
    localparam logic [7:0] IDX_ERR_CHAN = 8'h5d;
    localparam logic [7:0] IDX_ERR_FLAG = 8'h5e;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h5f;
    localparam int IDX_LSB = 2;
    localparam int IDX_MSB = 9;
    localparam int FLAG_W = 2;
    localparam int ADDR_LSB = 12;
    localparam int ADDR_W = 20;
    localparam int SYN_W = 8;
    localparam int NUM_QW = 4;
    localparam int FLAG_SBE = 0;
    localparam int FLAG_MBE = 1;
    localparam logic [1:0] FLAG_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

    typedef struct packed {
        logic [31:0] addr;
        logic chan_b;
        logic [NUM_QW-1:0] sbe;
        logic [NUM_QW-1:0] mbe;
        logic [NUM_QW*SYN_W-1:0] syn;
    } delog_err_t;

    typedef struct packed {
        logic valid;
        logic multi;
        logic [SYN_W-1:0] syn;
    } delog_pick_t;

    typedef enum logic [1:0] {
        DELOG_IDLE = 2'b00,
        DELOG_SBE = 2'b01,
        DELOG_MBE = 2'b11
    } delog_state_t;
endpackage

// *** verilog/delog_prio.sv ***
// Purpose: Fixed-priority pick of the syndrome source among quadwords
// Assumes: Syndromes packed quadword 0 in the low byte
// Notes: Purely combinational
`timescale 1ns/1ps
module delog_prio #(
    parameter int NQ = 4,
    parameter int SW = 8
) (
    input wire logic [NQ-1:0] sbe,
    input wire logic [NQ-1:0] mbe,
    input wire logic [NQ*SW-1:0] syn,
    output delog_pkg::delog_pick_t pick
);
    always_comb begin
        pick = '0;
        for (int i = NQ - 1; i >= 0; i--) begin
            if (sbe[i]) begin
                pick.valid = 1'b1;
                pick.multi = 1'b0;
                pick.syn = syn[i*SW +: SW];
            end
        end
        for (int i = NQ - 1; i >= 0; i--) begin
            if (mbe[i]) begin
                pick.valid = 1'b1;
                pick.multi = 1'b1;
                pick.syn = syn[i*SW +: SW];
            end
        end
    end
endmodule

// *** verilog/delog_ahb.sv ***
// Purpose: AHB-Lite slave front end, latches the address phase
// Assumes: Zero wait states, single word transfers
// Notes: Response is always OKAY
`timescale 1ns/1ps
module delog_ahb (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    output logic wr_pend,
    output logic rd_pend,
    output logic [7:0] acc_idx
);
    logic take;
    assign take = hsel && hready && (htrans == delog_pkg::HTRANS_NONSEQ);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            acc_idx <= 8'h00;
        end else if (hready) begin
            wr_pend <= take && hwrite;
            rd_pend <= take && !hwrite;
            acc_idx <= haddr[delog_pkg::IDX_MSB:delog_pkg::IDX_LSB];
        end
    end
endmodule

// *** verilog/delog_top.sv ***
// Purpose: DRAM ECC error logger with AHB-Lite registers and interrupt
// Assumes: Error report arrives as a one-cycle pulse in the hclk domain
// Notes: Log content has no reset value; flags and mask do
`timescale 1ns/1ps
module delog_top #(
    parameter int NUM_QW = delog_pkg::NUM_QW
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic err_valid,
    input wire delog_pkg::delog_err_t err_in,
    output logic irq
);
    // Bus side
    logic wr_pend;
    logic [7:0] acc_idx;
    logic addr_take;
    logic [7:0] addr_idx;
    logic rd_take;
    logic wr_flag;
    logic wr_mask;

    // Error side
    delog_pkg::delog_pick_t pick;
    logic rec;
    logic rec_single;
    logic rec_multi;
    logic [1:0] clr;
    logic [1:0] set;

    // Flags, lock and interrupt
    logic [1:0] flag_r;
    logic [1:0] flag_nxt;
    delog_pkg::delog_state_t state_r;
    delog_pkg::delog_state_t state_nxt;
    logic [1:0] mask_r;
    logic irq_nxt;

    // Log fields, deliberately without reset
    logic [delog_pkg::ADDR_W-1:0] addr_r;
    logic [delog_pkg::SYN_W-1:0] syn_r;
    logic chan_r;

    // Read words
    logic [31:0] addr_word;
    logic [31:0] syn_word;
    logic [31:0] chan_word;
    logic [31:0] flag_word;
    logic [31:0] mask_word;
    logic [31:0] rd_nxt;

    // Address phase decode for the read path
    assign addr_take = hsel && hready && (htrans == delog_pkg::HTRANS_NONSEQ);
    assign addr_idx = haddr[delog_pkg::IDX_MSB:delog_pkg::IDX_LSB];
    assign rd_take = addr_take && !hwrite;

    // Data phase write strobes
    assign wr_flag = wr_pend && (acc_idx == delog_pkg::IDX_ERR_FLAG);
    assign wr_mask = wr_pend && (acc_idx == delog_pkg::IDX_IRQ_MASK);

    delog_ahb u_ahb (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hready(hready),
        .wr_pend(wr_pend),
        .rd_pend(),
        .acc_idx(acc_idx)
    );

    delog_prio #(
        .NQ(NUM_QW),
        .SW(delog_pkg::SYN_W)
    ) u_prio (
        .sbe(err_in.sbe),
        .mbe(err_in.mbe),
        .syn(err_in.syn),
        .pick(pick)
    );

    always_comb begin
        case (state_r)
            delog_pkg::DELOG_IDLE: rec = err_valid && pick.valid;
            delog_pkg::DELOG_SBE: rec = err_valid && pick.valid && pick.multi;
            delog_pkg::DELOG_MBE: rec = 1'b0;
            default: rec = 1'b0;
        endcase
    end

    // Recorded error sorted by kind
    assign rec_single = rec && !pick.multi;
    assign rec_multi = rec && pick.multi;
    assign set[delog_pkg::FLAG_SBE] = rec_single;
    assign set[delog_pkg::FLAG_MBE] = rec_multi;
    assign clr = wr_flag ? hwdata[delog_pkg::FLAG_W-1:0] : 2'h0;

    assign flag_nxt = (flag_r & ~clr) | set;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_r <= delog_pkg::FLAG_RST;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    // Lock state follows the flags so a partial clear keeps the lock
    always_comb begin
        case (flag_nxt)
            2'h0: state_nxt = delog_pkg::DELOG_IDLE;
            2'h1: state_nxt = delog_pkg::DELOG_SBE;
            default: state_nxt = delog_pkg::DELOG_MBE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= delog_pkg::DELOG_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Log has no reset; reads undefined until the first error
    always_ff @(posedge hclk) begin
        if (rec) begin
            addr_r <= err_in.addr[delog_pkg::ADDR_LSB +: delog_pkg::ADDR_W];
        end
    end

    always_ff @(posedge hclk) begin
        if (rec) begin
            syn_r <= pick.syn;
        end
    end

    always_ff @(posedge hclk) begin
        if (rec) begin
            chan_r <= err_in.chan_b;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mask_r <= delog_pkg::MASK_RST;
        end else if (wr_mask) begin
            mask_r <= hwdata[delog_pkg::FLAG_W-1:0];
        end
    end

    // Mask bit of one lets the flag through; next flags keep irq in step
    assign irq_nxt = |(flag_nxt & mask_r);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= irq_nxt;
        end
    end

    // Reserved low address bits read zero
    assign addr_word = {addr_r, {delog_pkg::ADDR_LSB{1'b0}}};
    assign syn_word = {{(32 - delog_pkg::SYN_W){1'b0}}, syn_r};
    assign chan_word = {31'h0, chan_r};
    // Flag reads see same-cycle updates
    assign flag_word = {30'h0, flag_nxt};
    assign mask_word = {30'h0, mask_r};

    // Read mux on the address phase; unmapped indices read zero
    always_comb begin
        rd_nxt = 32'h0;
        case (addr_idx)
            delog_pkg::IDX_ERR_ADDR: rd_nxt = addr_word;
            delog_pkg::IDX_ERR_SYN: rd_nxt = syn_word;
            delog_pkg::IDX_ERR_CHAN: rd_nxt = chan_word;
            delog_pkg::IDX_ERR_FLAG: rd_nxt = flag_word;
            delog_pkg::IDX_IRQ_MASK: rd_nxt = mask_word;
            default: rd_nxt = 32'h0;
        endcase
    end

    // Read data registered at address phase so it is valid in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (rd_take) begin
            hrdata <= rd_nxt;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end
endmodule

// *** bench/delog_checker.sv ***
// Purpose: Port checks for delog_top
// Assumes: Zero-wait bus
// Notes: Log values are left to the bench
`timescale 1ns/1ps
module delog_checker #(
    parameter int NUM_QW = 4
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic err_valid,
    input wire logic irq
);
    logic tk;
    logic rd;
    logic [7:0] ix;
    logic [2:0] wr_r;
    assign tk = hsel && hready && htrans == 2'h2;
    assign rd = tk && !hwrite;
    assign ix = haddr[9:2];
    // Mask and clear writes move irq a few edges late
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_r <= 3'h0;
        end else begin
            wr_r <= {wr_r[1:0], tk && hwrite};
        end
    end
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    ready_high_a: assert property (hreadyout) else $error("wait state");
    resp_okay_a: assert property (!hresp) else $error("error response");
    rdata_hold_a: assert property (!rd |=> $stable(hrdata)) else $error("rdata moved");
    addr_rsv_a: assert property (
        rd && ix == delog_pkg::IDX_ERR_ADDR |=> hrdata[11:0] == 12'h000)
        else $error("addr low bits");
    chan_rsv_a: assert property (
        rd && ix == delog_pkg::IDX_ERR_CHAN |=> hrdata[31:1] == 31'h0)
        else $error("chan high bits");
    unmapped_zero_a: assert property (
        rd && !(ix inside {[8'h58:8'h5f]}) |=> hrdata == 32'h0) else $error("unmapped read");
    irq_rise_a: assert property (
        $rose(irq) |-> $past(err_valid) || wr_r != 3'h0) else $error("irq rose alone");
    irq_fall_a: assert property (
        $fell(irq) |-> wr_r != 3'h0) else $error("irq fell alone");
endmodule

bind delog_top delog_checker #(.NUM_QW(NUM_QW)) chk_i (.hclk, .hresetn, .hsel, .haddr,
    .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .err_valid, .irq);

// *** bench/delog_mem_model.sv ***
// Purpose: Memory side reporting checked chunks
// Assumes: One report per call
// Notes: Bus scrambled between reports
`timescale 1ns/1ps
module delog_mem_model (
    input wire logic hclk,
    output logic err_valid,
    output delog_pkg::delog_err_t err_in
);
    initial begin
        err_valid = 1'b0;
        err_in = '0;
    end
    task automatic send(input delog_pkg::delog_err_t e, input int gap);
        repeat (gap) @(posedge hclk);
        err_valid <= 1'b1;
        err_in <= e;
        @(posedge hclk);
        err_valid <= 1'b0;
        err_in <= ~e;
    endtask
endmodule

// *** bench/delog_top_tb.sv ***
// Purpose: Register test of delog_top
// Assumes: hready looped from hreadyout
// Notes: Log unknown until an error
`timescale 1ns/1ps
module delog_top_tb;
    logic hclk, hresetn, hsel, hwrite, irq, err_valid, hready, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    delog_pkg::delog_err_t err_in;
    int errors = 0;
    int checks_done = 0;
    delog_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout(hready), .hresp, .err_valid, .err_in, .irq);
    delog_mem_model mem (.hclk, .err_valid, .err_in);
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] ix, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, ix, 2'h0};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [7:0] ix, input logic [31:0] exp);
        bus(1'b0, ix, 32'h0);
        chk(rd, exp);
    endtask
    task automatic log4(input logic [31:0] a, input logic [7:0] s, input logic c,
        input logic [1:0] f);
        rchk(delog_pkg::IDX_ERR_ADDR, a);
        rchk(delog_pkg::IDX_ERR_SYN, {24'h0, s});
        rchk(delog_pkg::IDX_ERR_CHAN, {31'h0, c});
        rchk(delog_pkg::IDX_ERR_FLAG, {30'h0, f});
    endtask
    // Quadword n carries syndrome byte 11 times n plus one
    task automatic ev(input logic [31:0] a, input logic c, input logic [3:0] s, m, int g);
        mem.send('{a, c, s, m, 32'h44332211}, g);
    endtask
    task automatic finish_test;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        #50000;
        errors++;
        finish_test;
    end
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rchk(delog_pkg::IDX_ERR_FLAG, 32'h0);
        rchk(delog_pkg::IDX_IRQ_MASK, 32'h0);
        ev(32'habcd_e123, 1'b0, 4'b0110, 4'h0, 0);
        log4(32'habcd_e000, 8'h22, 1'b0, 2'h1);
        chk({31'h0, irq}, 32'h0);
        bus(1'b1, delog_pkg::IDX_IRQ_MASK, 32'h3);
        ev(32'h1357_9000, 1'b1, 4'b0001, 4'h0, 3);
        bus(1'b1, delog_pkg::IDX_ERR_ADDR, 32'hffff_ffff);
        log4(32'habcd_e000, 8'h22, 1'b0, 2'h1);
        chk({31'h0, irq}, 32'h1);
        $display("test single done");
        ev(32'h2468_a5a5, 1'b1, 4'b0001, 4'b1100, 0);
        log4(32'h2468_a000, 8'h33, 1'b1, 2'h3);
        ev(32'h9999_9999, 1'b0, 4'h0, 4'b0001, 0);
        log4(32'h2468_a000, 8'h33, 1'b1, 2'h3);
        $display("test multi done");
        bus(1'b1, delog_pkg::IDX_ERR_FLAG, 32'h3);
        rchk(delog_pkg::IDX_ERR_FLAG, 32'h0);
        chk({31'h0, irq}, 32'h0);
        ev(32'hfedc_b0ff, 1'b1, 4'h0, 4'b1000, 2);
        log4(32'hfedc_b000, 8'h44, 1'b1, 2'h2);
        chk({31'h0, irq}, 32'h1);
        rchk(8'h40, 32'h0);
        $display("test rearm done");
        bus(1'b1, delog_pkg::IDX_ERR_FLAG, 32'h3);
        ev(32'h0000_1000, 1'b0, 4'b0100, 4'h0, 0);
        log4(32'h0000_1000, 8'h33, 1'b0, 2'h1);
        // Multi-bit error lands on the edge that applies the clear
        fork
            bus(1'b1, delog_pkg::IDX_ERR_FLAG, 32'h3);
            ev(32'h7654_3210, 1'b1, 4'h0, 4'b0010, 1);
        join
        log4(32'h7654_3000, 8'h22, 1'b1, 2'h2);
        chk({31'h0, irq}, 32'h1);
        $display("test collide done");
        finish_test;
    end
endmodule
